//--- asu_cfg.svh
// Register map, field positions, reset values and baud constants of the auxiliary serial port.
// Assumes inclusion by bare name from the design modules and the bench.
`ifndef ASU_CFG_SVH
`define ASU_CFG_SVH
`define ASU_IDX_STATUS   2'h0
`define ASU_IDX_RXBYTE   2'h1
`define ASU_IDX_TXBYTE   2'h2
`define ASU_MODE_HI      7
`define ASU_MODE_LO      5
`define ASU_BIT_RTS      4
`define ASU_BIT_CTS      3
`define ASU_BIT_OVF      2
`define ASU_BIT_RXW      1
`define ASU_BIT_TXE      0
`define ASU_MODE_OFF     3'h7
`define ASU_MODE_RESET   3'h7
`define ASU_CLK_HZ       200000000
`define ASU_OVERSAMPLE   16
`define ASU_BAUD0        115200
`define ASU_BAUD1        57600
`define ASU_BAUD2        38400
`define ASU_BAUD3        19200
`define ASU_BAUD4        9600
`define ASU_BAUD5        4800
`define ASU_BAUD6        2400
`define ASU_RX_DEPTH     5
`define ASU_TX_DEPTH     1
`endif

//--- asu_pkg.sv
// Types shared by the auxiliary serial port modules.
// Assumes nothing beyond the configuration header.
package asu_pkg;
  typedef enum logic [3:0] {
    ASU_TX_IDLE  = 4'h1,
    ASU_TX_START = 4'h2,
    ASU_TX_DATA  = 4'h4,
    ASU_TX_STOP  = 4'h8
  } asu_tx_state_t;
  typedef enum logic [3:0] {
    ASU_RX_IDLE  = 4'h1,
    ASU_RX_START = 4'h2,
    ASU_RX_DATA  = 4'h4,
    ASU_RX_STOP  = 4'h8
  } asu_rx_state_t;
endpackage

//--- asu_stream_if.sv
// Valid/ready byte stream carried between the serial port and its queues.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface asu_stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

//--- asu_fifo.sv
// Small first-in first-out queue with registered head data.
// Assumes a single clock; the head word is valid whenever rd.valid is high.
`timescale 1ns/1ps
module asu_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic resetn_in,
  // Streams
  asu_stream_if.snk wr,
  asu_stream_if.src rd
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  generate
    if (DEPTH < 1 || W < 1) begin : g_bad
      $error("asu_fifo needs DEPTH and W of at least one");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wptr;
    logic [AW-1:0]           rptr;
    logic [CW-1:0]           count;
    logic [W-1:0]            head;
  } asu_fifo_st_t;

  asu_fifo_st_t s_reg;
  asu_fifo_st_t s_next;
  logic         push;
  logic         pop;

  assign wr.ready = (s_reg.count != FULL);
  assign rd.valid = (s_reg.count != '0);
  assign rd.data  = s_reg.head;
  assign push     = wr.valid & wr.ready;
  assign pop      = rd.valid & rd.ready;

  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.mem[s_reg.wptr] = wr.data;
      s_next.wptr = (s_reg.wptr == LAST) ? '0 : s_reg.wptr + 1'b1;
    end
    if (pop) begin
      s_next.rptr = (s_reg.rptr == LAST) ? '0 : s_reg.rptr + 1'b1;
    end
    s_next.count = s_reg.count + CW'(push) - CW'(pop);
    // The head register follows the updated memory so a word written into an empty queue shows at once.
    s_next.head = s_next.mem[s_next.rptr];
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule

//--- asu_baud.sv
// Oversampling tick generator for the seven fixed line rates.
// Assumes the mode code is stable between changes made by software.
`timescale 1ns/1ps
`include "asu_cfg.svh"
module asu_baud #(
  parameter int CLK_HZ = `ASU_CLK_HZ
) (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  // Rate selection
  input  wire logic [2:0] mode_in,
  output logic            tick_out
);
  localparam int OS = `ASU_OVERSAMPLE;

  generate
    if (CLK_HZ / (OS * `ASU_BAUD0) < 2 || CLK_HZ / (OS * `ASU_BAUD6) > 65535) begin : g_bad
      $error("asu_baud cannot divide this clock to the line rates");
    end
  endgenerate

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } asu_baud_st_t;

  asu_baud_st_t s_reg;
  asu_baud_st_t s_next;
  logic [15:0]  div;

  always_comb begin
    case (mode_in)
      3'h0:    div = 16'(CLK_HZ / (OS * `ASU_BAUD0));
      3'h1:    div = 16'(CLK_HZ / (OS * `ASU_BAUD1));
      3'h2:    div = 16'(CLK_HZ / (OS * `ASU_BAUD2));
      3'h3:    div = 16'(CLK_HZ / (OS * `ASU_BAUD3));
      3'h4:    div = 16'(CLK_HZ / (OS * `ASU_BAUD4));
      3'h5:    div = 16'(CLK_HZ / (OS * `ASU_BAUD5));
      default: div = 16'(CLK_HZ / (OS * `ASU_BAUD6));
    endcase
    s_next      = s_reg;
    s_next.tick = 1'b0;
    // A rate change may shorten the divisor below the count, so compare with at-or-above.
    if (s_reg.cnt >= div - 16'h0001) begin
      s_next.cnt  = 16'h0000;
      s_next.tick = (mode_in != `ASU_MODE_OFF);
    end else begin
      s_next.cnt = s_reg.cnt + 16'h0001;
    end
  end

  assign tick_out = s_reg.tick;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule

//--- asu_uart.sv
// Auxiliary serial port: register slave, receive queue, one-byte transmit holding queue and 8N1 line engine.
// Assumes an Avalon-MM master on clk_in and an asynchronous serial partner on the line pins.
// Function
// - Status bits 7-5 form a read/write mode field for rate and setting.
// - Modes 0-6 select 115200 down to 2400 baud, all 8N1.
// - Mode seven turns the port off and silences the interrupt.
// - Status bit 4 is writable and drives the request-to-send line.
// - Status bit 3 reads the clear-to-send input level.
// - Status bit 2 reads back the receive overflow flag.
// - Status bit 1 is set while a received byte waits.
// - Status bit 0 is set while the transmit buffer can take a byte.
// - Reading offset one returns the oldest received byte.
// - Writing offset two queues a byte for transmission.
// - Five received bytes are queued; one byte waits for transmission.
// - The interrupt stays high while received data waits.
// - The interrupt also rises when the transmit buffer turns empty.
// - Reading status clears the pending interrupt.
// - Standard build uses transmit, receive, request and clear-to-send lines.
// - Reduced build uses only the data lines; handshakes stay unused.
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
`include "asu_cfg.svh"
module asu_uart #(
  parameter int CLK_HZ    = `ASU_CLK_HZ,
  parameter bit HANDSHAKE = 1'b1
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [3:0]  avs_byteenable_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // Serial line
  input  wire logic        rxd_in,
  output logic             txd_out,
  input  wire logic        cts_in,
  output logic             rts_out,
  // Interrupt
  output logic             irq_out
);
  typedef struct packed {
    logic [2:0]             rxd_s;
    logic [2:0]             cts_s;
    logic                   rxd_f;
    logic                   cts_f;
    logic [2:0]             mode;
    logic                   rts;
    logic                   ovf;
    logic                   tx_pend;
    logic                   tx_empty_d;
    logic                   ack;
    logic [7:0]             rdata;
    logic                   txd;
    asu_pkg::asu_tx_state_t tx_st;
    logic [3:0]             tx_tick;
    logic [2:0]             tx_bit;
    logic [7:0]             tx_sh;
    asu_pkg::asu_rx_state_t rx_st;
    logic [3:0]             rx_tick;
    logic [2:0]             rx_bit;
    logic [7:0]             rx_sh;
  } asu_uart_st_t;

  asu_uart_st_t s_reg;
  asu_uart_st_t s_next;
  logic         tick;
  logic         off;
  logic         req;
  logic         tx_empty;
  logic         rx_push;
  logic         rx_pop;
  logic         tx_push;
  logic         tx_pop;
  logic [7:0]   status;

  asu_stream_if #(.W(8)) rx_wr ();
  asu_stream_if #(.W(8)) rx_rd ();
  asu_stream_if #(.W(8)) tx_wr ();
  asu_stream_if #(.W(8)) tx_rd ();

  asu_fifo #(.W(8), .DEPTH(`ASU_RX_DEPTH)) u_rx_fifo (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .wr        (rx_wr.snk),
    .rd        (rx_rd.src)
  );

  asu_fifo #(.W(8), .DEPTH(`ASU_TX_DEPTH)) u_tx_fifo (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .wr        (tx_wr.snk),
    .rd        (tx_rd.src)
  );

  asu_baud #(.CLK_HZ(CLK_HZ)) u_baud (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .mode_in   (s_reg.mode),
    .tick_out  (tick)
  );

  assign rx_wr.valid = rx_push;
  assign rx_wr.data  = s_reg.rx_sh;
  assign rx_rd.ready = rx_pop;
  assign tx_wr.valid = tx_push;
  assign tx_wr.data  = avs_writedata_in[7:0];
  assign tx_rd.ready = tx_pop;

  assign off      = (s_reg.mode == `ASU_MODE_OFF);
  assign tx_empty = ~tx_rd.valid;
  // The request is served once; waitrequest drops in the cycle after acceptance.
  assign req                 = (avs_read_in | avs_write_in) & ~s_reg.ack;
  assign avs_waitrequest_out = req;
  assign avs_readdata_out    = {24'h000000, s_reg.rdata};

  always_comb begin
    status                             = 8'h00;
    status[`ASU_MODE_HI:`ASU_MODE_LO]  = s_reg.mode;
    status[`ASU_BIT_RTS]               = s_reg.rts;
    status[`ASU_BIT_CTS]               = HANDSHAKE ? s_reg.cts_f : 1'b0;
    status[`ASU_BIT_OVF]               = s_reg.ovf;
    status[`ASU_BIT_RXW]               = rx_rd.valid;
    status[`ASU_BIT_TXE]               = tx_empty;
  end

  always_comb begin
    s_next     = s_reg;
    rx_push    = 1'b0;
    rx_pop     = 1'b0;
    tx_push    = 1'b0;
    tx_pop     = 1'b0;
    s_next.ack = req;
    // Pin inputs: a new level counts only when the second and third stages agree.
    s_next.rxd_s = {s_reg.rxd_s[1:0], rxd_in};
    s_next.cts_s = {s_reg.cts_s[1:0], cts_in};
    if (s_reg.rxd_s[1] == s_reg.rxd_s[2]) begin
      s_next.rxd_f = s_reg.rxd_s[2];
    end
    if (s_reg.cts_s[1] == s_reg.cts_s[2]) begin
      s_next.cts_f = s_reg.cts_s[2];
    end

    // Register reads; unmapped reads return zero.
    if (req && avs_read_in) begin
      if (avs_address_in == {`ASU_IDX_STATUS, 2'b00}) begin
        s_next.rdata   = status;
        s_next.tx_pend = 1'b0;
        s_next.ovf     = 1'b0;
      end else if (avs_address_in == {`ASU_IDX_RXBYTE, 2'b00}) begin
        s_next.rdata = rx_rd.data;
        rx_pop       = rx_rd.valid;
      end else begin
        s_next.rdata = 8'h00;
      end
    end
    // Register writes; unmapped writes are ignored.
    if (req && avs_write_in && avs_byteenable_in[0]) begin
      if (avs_address_in == {`ASU_IDX_STATUS, 2'b00}) begin
        s_next.mode = avs_writedata_in[`ASU_MODE_HI:`ASU_MODE_LO];
        s_next.rts  = avs_writedata_in[`ASU_BIT_RTS];
      end else if (avs_address_in == {`ASU_IDX_TXBYTE, 2'b00}) begin
        tx_push = tx_wr.ready;
      end
    end

    // Transmitter: one bit lasts sixteen ticks.
    case (s_reg.tx_st)
      asu_pkg::ASU_TX_IDLE: begin
        s_next.txd = 1'b1;
        if (tx_rd.valid && !off) begin
          tx_pop         = 1'b1;
          s_next.tx_sh   = tx_rd.data;
          s_next.tx_st   = asu_pkg::ASU_TX_START;
          s_next.txd     = 1'b0;
          s_next.tx_tick = 4'h0;
        end
      end
      asu_pkg::ASU_TX_START: begin
        if (tick) begin
          s_next.tx_tick = s_reg.tx_tick + 4'h1;
          if (s_reg.tx_tick == 4'hf) begin
            s_next.txd    = s_reg.tx_sh[0];
            s_next.tx_sh  = {1'b0, s_reg.tx_sh[7:1]};
            s_next.tx_bit = 3'h0;
            s_next.tx_st  = asu_pkg::ASU_TX_DATA;
          end
        end
      end
      asu_pkg::ASU_TX_DATA: begin
        if (tick) begin
          s_next.tx_tick = s_reg.tx_tick + 4'h1;
          if (s_reg.tx_tick == 4'hf) begin
            if (s_reg.tx_bit == 3'h7) begin
              s_next.txd   = 1'b1;
              s_next.tx_st = asu_pkg::ASU_TX_STOP;
            end else begin
              s_next.txd    = s_reg.tx_sh[0];
              s_next.tx_sh  = {1'b0, s_reg.tx_sh[7:1]};
              s_next.tx_bit = s_reg.tx_bit + 3'h1;
            end
          end
        end
      end
      asu_pkg::ASU_TX_STOP: begin
        if (tick) begin
          s_next.tx_tick = s_reg.tx_tick + 4'h1;
          if (s_reg.tx_tick == 4'hf) begin
            s_next.tx_st = asu_pkg::ASU_TX_IDLE;
          end
        end
      end
      default: begin
        s_next.tx_st = asu_pkg::ASU_TX_IDLE;
        s_next.txd   = 1'b1;
      end
    endcase

    // Receiver: sampling is anchored at the middle of the start bit.
    case (s_reg.rx_st)
      asu_pkg::ASU_RX_IDLE: begin
        if (tick && !s_reg.rxd_f) begin
          s_next.rx_st   = asu_pkg::ASU_RX_START;
          s_next.rx_tick = 4'h0;
        end
      end
      asu_pkg::ASU_RX_START: begin
        if (tick) begin
          s_next.rx_tick = s_reg.rx_tick + 4'h1;
          if (s_reg.rx_tick == 4'h7) begin
            s_next.rx_tick = 4'h0;
            s_next.rx_bit  = 3'h0;
            // A glitch shorter than half a bit is not a start bit.
            s_next.rx_st = s_reg.rxd_f ? asu_pkg::ASU_RX_IDLE : asu_pkg::ASU_RX_DATA;
          end
        end
      end
      asu_pkg::ASU_RX_DATA: begin
        if (tick) begin
          s_next.rx_tick = s_reg.rx_tick + 4'h1;
          if (s_reg.rx_tick == 4'hf) begin
            s_next.rx_sh  = {s_reg.rxd_f, s_reg.rx_sh[7:1]};
            s_next.rx_bit = s_reg.rx_bit + 3'h1;
            if (s_reg.rx_bit == 3'h7) begin
              s_next.rx_st = asu_pkg::ASU_RX_STOP;
            end
          end
        end
      end
      asu_pkg::ASU_RX_STOP: begin
        if (tick) begin
          s_next.rx_tick = s_reg.rx_tick + 4'h1;
          if (s_reg.rx_tick == 4'hf) begin
            s_next.rx_st = asu_pkg::ASU_RX_IDLE;
            // A low stop bit is a framing error and the byte is discarded.
            if (s_reg.rxd_f) begin
              rx_push = rx_wr.ready;
              if (!rx_wr.ready) begin
                s_next.ovf = 1'b1;
              end
            end
          end
        end
      end
      default: begin
        s_next.rx_st = asu_pkg::ASU_RX_IDLE;
      end
    endcase

    // Set wins over the status-read clear.
    s_next.tx_empty_d = tx_empty;
    if (tx_empty && !s_reg.tx_empty_d) begin
      s_next.tx_pend = 1'b1;
    end
    if (off) begin
      s_next.tx_st   = asu_pkg::ASU_TX_IDLE;
      s_next.rx_st   = asu_pkg::ASU_RX_IDLE;
      s_next.txd     = 1'b1;
      s_next.tx_pend = 1'b0;
    end
  end

  assign txd_out = s_reg.txd;
  assign rts_out = HANDSHAKE ? s_reg.rts : 1'b0;
  assign irq_out = ~off & (rx_rd.valid | s_reg.tx_pend);

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_reg         <= '0;
      s_reg.rxd_s   <= 3'h7;
      s_reg.cts_s   <= 3'h0;
      s_reg.rxd_f   <= 1'b1;
      s_reg.mode    <= `ASU_MODE_RESET;
      s_reg.txd     <= 1'b1;
      s_reg.tx_empty_d <= 1'b1;
      s_reg.tx_st   <= asu_pkg::ASU_TX_IDLE;
      s_reg.rx_st   <= asu_pkg::ASU_RX_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  localparam int ANS_MAX = 1;

  a_off_irq_quiet: assert property (@(posedge clk_in) disable iff (!resetn_in)
    off |-> !irq_out ##1 (s_reg.tx_st == asu_pkg::ASU_TX_IDLE && !s_reg.tx_pend && txd_out))
    else $error("port not quiet while off");
  a_rx_level_irq: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (!off && rx_rd.valid) |-> irq_out) else $error("interrupt low while receive data waits");
  a_tx_edge_irq: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (!off && !$past(off) && tx_empty && !s_reg.tx_empty_d) |=> (off || (irq_out && s_reg.tx_pend)))
    else $error("no interrupt on transmit empty");
  a_status_read_clear: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (req && avs_read_in && avs_address_in == 4'h0 && !(tx_empty && !s_reg.tx_empty_d)) |=> !s_reg.tx_pend)
    else $error("status read left interrupt pending");
  a_rts_drive: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (req && avs_write_in && avs_byteenable_in[0] && avs_address_in == 4'h0) |=> ##1
    (rts_out == (HANDSHAKE & $past(avs_writedata_in[4], 2)))) else $error("request-to-send does not follow bit 4");
  a_overflow_set: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (tick && s_reg.rx_st == asu_pkg::ASU_RX_STOP && s_reg.rx_tick == 4'hf && s_reg.rxd_f && !rx_wr.ready && !off)
    |=> s_reg.ovf && $stable(rx_rd.valid)) else $error("overflow not flagged");
  a_status_flags: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (s_reg.ack && avs_read_in && avs_address_in == 4'h0) |-> (avs_readdata_out[1] == $past(rx_rd.valid)
    && avs_readdata_out[0] == $past(tx_empty))) else $error("status flags disagree with queues");
  a_idle_line_high: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (s_reg.tx_st == asu_pkg::ASU_TX_IDLE || s_reg.tx_st == asu_pkg::ASU_TX_STOP) |-> txd_out)
    else $error("line not high outside a character");
  a_start_bit_low: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $rose(s_reg.tx_st == asu_pkg::ASU_TX_START) |-> !txd_out) else $error("start bit not low");
  a_bus_answer: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (avs_read_in || avs_write_in) |-> ##[0:ANS_MAX] !avs_waitrequest_out) else $error("bus request not answered");

  c_rx_byte: cover property (@(posedge clk_in) disable iff (!resetn_in) rx_push);
  c_overflow: cover property (@(posedge clk_in) disable iff (!resetn_in) $rose(s_reg.ovf));
  c_tx_start: cover property (@(posedge clk_in) disable iff (!resetn_in) tx_pop);
  c_irq: cover property (@(posedge clk_in) disable iff (!resetn_in) $rose(irq_out));
endmodule

//--- asu_serial_peer.sv
// Behavioural serial device on the far side of the auxiliary serial port.
// Assumes the bench sets bit_cyc to the line's bit time in clk_in cycles before any traffic.
`timescale 1ns/1ps
module asu_serial_peer (
  // Clock
  input  wire logic clk_in,
  // Serial line
  input  wire logic txd_in,
  output logic      rxd_out,
  output logic      cts_out
);
  int         bit_cyc = 32;
  int         n_framing = 0;
  logic [7:0] got[$];
  logic [7:0] sh;
  initial begin
    rxd_out = 1'b1;
    cts_out = 1'b0;
  end
  // Sampling at mid-bit tolerates a first bit that is up to one tick short.
  always begin : rx_side
    @(negedge txd_in);
    repeat (bit_cyc / 2) @(posedge clk_in);
    if (txd_in === 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        repeat (bit_cyc) @(posedge clk_in);
        sh[i] = txd_in;
      end
      repeat (bit_cyc) @(posedge clk_in);
      if (txd_in !== 1'b1) n_framing++;
      else got.push_back(sh);
    end
  end
  // The line is left high after the stop bit, as an idle line with a pull-up.
  task automatic send(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_in);
      rxd_out <= fr[i];
      repeat (bit_cyc - 1) @(posedge clk_in);
    end
  endtask
  task automatic set_cts(input logic v);
    @(posedge clk_in);
    cts_out <= v;
  endtask
endmodule

//--- asu_uart_bench.sv
// Self-checking bench for the auxiliary serial port: Avalon-MM master tasks and one serial peer.
// Assumes a lowered CLK_HZ so that one bit at 115200 baud lasts 32 clock cycles.
`timescale 1ns/1ps
`include "asu_cfg.svh"
module asu_uart_bench;
  localparam int         CLK      = 3686400;
  localparam int         BAUD [7] = '{`ASU_BAUD0, `ASU_BAUD1, `ASU_BAUD2, `ASU_BAUD3, `ASU_BAUD4, `ASU_BAUD5,
                                      `ASU_BAUD6};
  localparam logic [3:0] A_ST     = 4'h0;
  localparam logic [3:0] A_RX     = 4'h4;
  localparam logic [3:0] A_TX     = 4'h8;
  localparam logic [3:0] A_NONE   = 4'hc;
  logic        clk_in            = 1'b0;
  logic        resetn_in         = 1'b0;
  logic [3:0]  avs_address_in    = 4'h0;
  logic        avs_read_in       = 1'b0;
  logic        avs_write_in      = 1'b0;
  logic [3:0]  avs_byteenable_in = 4'h1;
  logic [31:0] avs_writedata_in  = 32'h0;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  logic        rxd_in;
  logic        txd_out;
  logic        cts_in;
  logic        rts_out;
  logic        irq_out;
  logic [31:0] ttl_readdata;
  logic        ttl_rts;
  logic [31:0] rd;
  int          n_mismatch = 0;
  int          num_checks = 0;
  always #2.5 clk_in = ~clk_in;
  asu_uart #(.CLK_HZ(CLK), .HANDSHAKE(1'b1)) dut (
    .clk_in(clk_in), .resetn_in(resetn_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_byteenable_in(avs_byteenable_in), .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out), .rxd_in(rxd_in),
    .txd_out(txd_out), .cts_in(cts_in), .rts_out(rts_out), .irq_out(irq_out));
  asu_serial_peer peer (.clk_in(clk_in), .txd_in(txd_out), .rxd_out(rxd_in), .cts_out(cts_in));
  // The reduced build shares every input with dut; only its handshake side is watched.
  asu_uart #(.CLK_HZ(CLK), .HANDSHAKE(1'b0)) dut_ttl (
    .clk_in(clk_in), .resetn_in(resetn_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_byteenable_in(avs_byteenable_in), .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(ttl_readdata), .avs_waitrequest_out(), .rxd_in(rxd_in),
    .txd_out(), .cts_in(cts_in), .rts_out(ttl_rts), .irq_out());
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // The request stands until waitrequest is sampled low at a rising edge; read data are taken at that edge.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_in);
    avs_address_in   <= a;
    avs_write_in     <= wr;
    avs_read_in      <= !wr;
    avs_writedata_in <= {24'h0, d};
    do begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 100);
    if (n >= 100) chk(1'b0, 1'b1, "waitrequest stuck");
    q = avs_readdata_out;
    avs_read_in  <= 1'b0;
    avs_write_in <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 8'h0, rd);
    chk(rd, exp, what);
  endtask
  task automatic set_mode(input logic [2:0] m, input logic rts);
    bus(1'b1, A_ST, {m, rts, 4'h0}, rd);
    if (m < 3'h7) peer.bit_cyc = (CLK / (`ASU_OVERSAMPLE * BAUD[m])) * `ASU_OVERSAMPLE;
  endtask
  task automatic wait_rx(input int n);
    for (int i = 0; i < 40000 && peer.got.size() < n; i++) @(posedge clk_in);
  endtask
  task automatic t_reset;
    rd_chk(A_ST, 32'he1, "status after reset");
    chk(irq_out, 1'b0, "irq after reset");
    chk(txd_out, 1'b1, "idle line");
    chk(rts_out, 1'b0, "rts after reset");
    rd_chk(A_NONE, 32'h0, "unmapped read");
  endtask
  task automatic t_ctrl;
    set_mode(3'h0, 1'b1);
    rd_chk(A_ST, 32'h11, "mode and rts readback");
    chk(rts_out, 1'b1, "rts line high");
    peer.set_cts(1'b1);
    repeat (5) @(posedge clk_in);
    rd_chk(A_ST, 32'h19, "cts reflected");
    chk(ttl_readdata, 32'h11, "reduced build hides cts");
    chk(ttl_rts, 1'b0, "reduced build rts unused");
    chk(rts_out, 1'b1, "rts held");
    set_mode(3'h0, 1'b0);
    chk(rts_out, 1'b0, "rts line low");
  endtask
  task automatic t_tx;
    bus(1'b1, A_TX, 8'h5a, rd);
    bus(1'b1, A_TX, 8'hc3, rd);
    bus(1'b1, A_TX, 8'h3c, rd);
    rd_chk(A_ST, 32'h08, "tx buffer full");
    wait_rx(2);
    repeat (12 * 32) @(posedge clk_in);
    chk(peer.got.size(), 2, "third byte dropped");
    chk(peer.got[0], 8'h5a, "first byte on line");
    chk(peer.got[1], 8'hc3, "second byte on line");
    chk(peer.n_framing, 0, "stop bits high");
    chk(irq_out, 1'b1, "irq on tx empty");
    rd_chk(A_ST, 32'h09, "tx empty again");
    chk(irq_out, 1'b0, "irq cleared by status read");
    peer.got.delete();
  endtask
  task automatic t_rates;
    for (int m = 0; m < 7; m++) begin
      set_mode(m[2:0], 1'b0);
      bus(1'b1, A_TX, {m[3:0], ~m[3:0]}, rd);
      wait_rx(1);
      repeat (peer.bit_cyc) @(posedge clk_in);
      chk(peer.got.size(), 1, "byte at rate");
      chk(peer.got[0], {m[3:0], ~m[3:0]}, "byte value at rate");
      peer.got.delete();
    end
  endtask
  task automatic t_rx;
    set_mode(3'h0, 1'b0);
    bus(1'b0, A_ST, 8'h0, rd);
    for (int i = 0; i < 6; i++) peer.send(8'ha0 + i[7:0]);
    repeat (40) @(posedge clk_in);
    chk(irq_out, 1'b1, "irq while rx data");
    rd_chk(A_ST, 32'h0f, "overflow and waiting");
    chk(irq_out, 1'b1, "irq held by rx level");
    for (int i = 0; i < 5; i++) rd_chk(A_RX, 32'ha0 + i, "rx order");
    rd_chk(A_ST, 32'h09, "rx queue empty");
    chk(irq_out, 1'b0, "irq low when empty");
  endtask
  task automatic t_off;
    peer.send(8'h77);
    repeat (40) @(posedge clk_in);
    chk(irq_out, 1'b1, "irq before off");
    set_mode(3'h7, 1'b0);
    chk(irq_out, 1'b0, "irq suppressed when off");
    rd_chk(A_ST, 32'heb, "byte kept when off");
    bus(1'b1, A_TX, 8'h11, rd);
    repeat (12 * 32) @(posedge clk_in);
    chk(txd_out, 1'b1, "line idle when off");
    chk(peer.got.size(), 0, "nothing sent when off");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_in);
    resetn_in <= 1'b1;
    t_reset();
    t_ctrl();
    t_tx();
    t_rates();
    t_rx();
    t_off();
    final_report();
  end
  // The full sequence needs about 36000 cycles; the limit leaves ample margin.
  initial begin
    repeat (95000) @(posedge clk_in);
    n_mismatch++;
    final_report();
  end
endmodule
